// ---- logic/pmi_pkg.sv ----
// Package with offsets, field positions and carrier types for the PWM interrupt status block.
`default_nettype none
package pmi_pkg;
  localparam logic [7:0] PMI_RAW_OFFSET = 8'h7A;
  localparam logic [7:0] PMI_MASKED_OFFSET = 8'h7B;
  localparam logic [7:0] PMI_CLEAR_OFFSET = 8'h7C;
  localparam int PMI_CHANNELS = 3;
  localparam int PMI_CYCLE_LSB = 0;
  localparam int PMI_SCRIPT_LSB = 3;
  localparam logic [5:0] PMI_FLAGS_RESET = 6'h00;
  localparam logic [7:0] PMI_READ_RESET = 8'h00;

  // Per-channel event pulses and mask bits, one bit per channel.
  typedef struct packed {
    logic [2:0] script_done;
    logic [2:0] cycle_done;
  } pmi_src_type;

  // Register access from the slave port decoder, one byte wide.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmi_req_type;
endpackage : pmi_pkg
`default_nettype wire

// ---- logic/pmi_irq_status.sv ----
// Raw and masked interrupt status of the three PWM timer channels.
// How it works
// - Read-only byte at 0x7B returns masked status of all three channels.
// - Masked bit equals raw flag AND the channel's cycle or script mask.
// - Cycle-done flag raised when the active command's PWM cycle completes.
// - Script-done flag raised when a script buffer task finishes its pattern.
// - Script-done masked flags of channels 2, 1, 0 sit at bits 5, 4, 3.
// - Cycle-done masked flags at bits 2, 1, 0; bits 7 and 6 reserved.
// - A masked bit of one means it drives the interrupt output.
// - Flags read zero when idle, one when pending, zero after reset.
// - Unmasked raw flags readable at 0x7A in the same layout.
// - Writing one at 0x7C clears that flag; zero does nothing.
// - Timer software reset leaves pending flags untouched.
`timescale 1ns/1ns
`default_nettype none
// One sticky flag: an event pulse sets it and a host write of one clears it.
module pmi_flag_cell #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_set,
  input wire logic i_clear,
  input wire logic i_enable,
  output logic o_flag,
  output logic o_masked
);

  logic flag_q;
  logic flag_d;

  // Set wins over a clear in the same cycle, so an event is never lost.
  always_comb begin
    flag_d = flag_q;
    if (i_set) begin
      flag_d = 1'b1;
    end else if (i_clear) begin
      flag_d = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      flag_q <= RESET_VALUE;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign o_flag = flag_q;
  // The masked output is combinational; the top module registers it before any pin.
  assign o_masked = flag_q & i_enable;
endmodule : pmi_flag_cell

// Six flags, their masking, the read port and the interrupt request.
module pmi_irq_status (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire pmi_pkg::pmi_src_type i_event,
  input wire pmi_pkg::pmi_src_type i_mask,
  input wire logic [2:0] i_timer_swreset,
  input wire pmi_pkg::pmi_req_type i_req,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic [5:0] o_masked,
  output logic o_pwm_irq
);

  // Two flags per channel: cycle-done in the low half, script-done in the high half.
  localparam int CHAN = pmi_pkg::PMI_CHANNELS;
  localparam int FLAG_COUNT = 2 * CHAN;

  // Event and mask carriers flattened into the register bit layout.
  logic [5:0] set_vec;
  logic [5:0] enable_vec;
  logic [5:0] clear_vec;

  // Flag state as the read port and the interrupt pin see it.
  logic [5:0] raw_flags;
  logic [5:0] masked_flags;
  logic [2:0] channel_irq;
  logic irq_any;

  // Address compares and decode results for the request of this cycle.
  logic addr_is_raw;
  logic addr_is_masked;
  logic addr_is_clear;
  logic clear_hit;
  logic raw_hit;
  logic masked_hit;
  logic [7:0] read_word;

  // Event pulses come from timers on this clock, so they need no synchroniser.
  always_comb begin
    set_vec = 6'h00;
    set_vec[pmi_pkg::PMI_CYCLE_LSB +: CHAN] = i_event.cycle_done;
    set_vec[pmi_pkg::PMI_SCRIPT_LSB +: CHAN] = i_event.script_done;
  end

  // A mask bit of one lets its flag reach the masked status and the pin.
  always_comb begin
    enable_vec = 6'h00;
    enable_vec[pmi_pkg::PMI_CYCLE_LSB +: CHAN] = i_mask.cycle_done;
    enable_vec[pmi_pkg::PMI_SCRIPT_LSB +: CHAN] = i_mask.script_done;
  end

  // Equality against the three register offsets.
  always_comb begin
    addr_is_raw = (i_req.addr == pmi_pkg::PMI_RAW_OFFSET);
    addr_is_masked = (i_req.addr == pmi_pkg::PMI_MASKED_OFFSET);
    addr_is_clear = (i_req.addr == pmi_pkg::PMI_CLEAR_OFFSET);
  end

  // Reads and the clear write share one priority chain on the address.
  always_comb begin
    clear_hit = 1'b0;
    raw_hit = 1'b0;
    masked_hit = 1'b0;
    if (addr_is_clear) begin
      clear_hit = i_req.wr;
    end else if (addr_is_masked) begin
      masked_hit = i_req.rd;
    end else if (addr_is_raw) begin
      raw_hit = i_req.rd;
    end
  end

  // Only bits 5 to 0 name a flag; the reserved upper bits of a clear write are ignored.
  always_comb begin
    clear_vec = 6'h00;
    if (clear_hit) begin
      clear_vec = i_req.wdata[5:0];
    end
  end

  // The timer software reset is not wired to the cells: only a clear write removes a flag.
  // Each cell holds one flag, so a bit's set, clear and mask never touch a neighbour.
  genvar gi;
  generate
    for (gi = 0; gi < FLAG_COUNT; gi++) begin : g_flag
      pmi_flag_cell #(
        .RESET_VALUE(pmi_pkg::PMI_FLAGS_RESET[gi])
      ) u_pmi_flag_cell (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_set(set_vec[gi]),
        .i_clear(clear_vec[gi]),
        .i_enable(enable_vec[gi]),
        .o_flag(raw_flags[gi]),
        .o_masked(masked_flags[gi])
      );
    end
  endgenerate

  // Each channel's share of the interrupt, cycle-done and script-done together.
  always_comb begin
    channel_irq = 3'h0;
    for (int c = 0; c < CHAN; c++) begin
      channel_irq[c] = masked_flags[pmi_pkg::PMI_CYCLE_LSB + c]
        | masked_flags[pmi_pkg::PMI_SCRIPT_LSB + c];
    end
  end

  // The request is a level that stays up while any masked flag is pending.
  always_comb begin
    irq_any = 1'b0;
    for (int k = 0; k < CHAN; k++) begin
      irq_any = irq_any | channel_irq[k];
    end
  end

  // Reserved bits 7 and 6 always read zero.
  // The masked read uses the live flags, registered on the same edge as o_masked, so the two agree.
  always_comb begin
    read_word = pmi_pkg::PMI_READ_RESET;
    if (masked_hit) begin
      read_word = {2'h0, masked_flags};
    end else if (raw_hit) begin
      read_word = {2'h0, raw_flags};
    end else begin
      read_word = pmi_pkg::PMI_READ_RESET;
    end
  end

  // Registered copy of the masked flags for the host side.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_masked <= pmi_pkg::PMI_FLAGS_RESET;
    end else begin
      o_masked <= masked_flags;
    end
  end

  // The pin request is registered so it cannot glitch on a mask write.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_pwm_irq <= 1'b0;
    end else begin
      o_pwm_irq <= irq_any;
    end
  end

  // A read of any address pulses the valid strobe; unmapped addresses return zero.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_req.rd;
    end
  end

  // Read data stands for exactly the one cycle of the valid strobe.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rdata <= pmi_pkg::PMI_READ_RESET;
    end else begin
      o_rdata <= read_word;
    end
  end
endmodule : pmi_irq_status
`default_nettype wire

// ---- verif/pmi_properties.sv ----
// Checker on the status block ports.
`timescale 1ns/1ns
`default_nettype none
module pmi_properties (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire pmi_pkg::pmi_src_type i_event,
  input wire pmi_pkg::pmi_src_type i_mask,
  input wire logic [2:0] i_timer_swreset,
  input wire pmi_pkg::pmi_req_type i_req,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic [5:0] o_masked,
  input wire logic o_pwm_irq
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  irq_or_a: assert property (o_pwm_irq == (|o_masked))
    else $error("irq request differs from masked OR");
  mask_gate_a: assert property (!i_mask[3] |=> !o_masked[3])
    else $error("masked flag set while mask low");
  flag_keep_a: assert property (i_event[5] ##1 i_timer_swreset[2] && !i_req.wr ##1 i_mask[5]
    |=> o_masked[5]) else $error("timer reset removed a flag");
  read_valid_a: assert property (o_rvalid == $past(i_req.rd))
    else $error("read valid not one cycle after read");
  reserved_zero_a: assert property (o_rvalid |-> o_rdata[7:6] == 2'h0)
    else $error("reserved read bits not zero");
  masked_read_a: assert property (i_req.rd && i_req.addr == pmi_pkg::PMI_MASKED_OFFSET
    |=> o_rdata[5:0] == o_masked) else $error("masked read differs from masked flags");
  cycle_set_a: assert property (i_event[0] ##1 i_mask[0] |=> o_masked[0])
    else $error("cycle event did not set its flag");
  script_set_a: assert property (i_event[3] ##1 i_mask[3] |=> o_masked[3])
    else $error("script event did not set its flag");
  clear_drop_a: assert property (i_req.wr && i_req.addr == pmi_pkg::PMI_CLEAR_OFFSET
    && i_req.wdata[1] && !i_event[1] |=> ##1 !o_masked[1]) else $error("clear write kept flag");
endmodule : pmi_properties
`default_nettype wire

// ---- verif/pmi_host.sv ----
// Host model.
`timescale 1ns/1ns
`default_nettype none
module pmi_host (
  input wire logic i_mclk,
  input wire logic i_rst,
  output var pmi_pkg::pmi_req_type o_req
);
  always @(posedge i_mclk)
    o_req <= i_rst ? '0 : {2'($urandom), 8'h7A + 2'($urandom), 8'($urandom)};
endmodule : pmi_host
`default_nettype wire

// ---- verif/tb_top.sv ----
// Bench.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int LIMIT = 20000;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic o_rvalid;
  logic o_pwm_irq;
  logic [2:0] i_timer_swreset = 3'h0;
  logic [5:0] o_masked;
  logic [7:0] o_rdata;
  pmi_pkg::pmi_src_type i_event = 6'h00;
  pmi_pkg::pmi_src_type i_mask = 6'h00;
  pmi_pkg::pmi_req_type i_req;
  int fails = 0;
  int cmp_count = 0;
  int cycles = 0;
  int f = 0;
  int m = 0;
  int rd_word = 0;
  int q[$];
  pmi_irq_status u_pmi_irq_status (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_event(i_event),
    .i_mask(i_mask),
    .i_timer_swreset(i_timer_swreset),
    .i_req(i_req),
    .o_rdata(o_rdata),
    .o_rvalid(o_rvalid),
    .o_masked(o_masked),
    .o_pwm_irq(o_pwm_irq)
  );
  pmi_host u_pmi_host (.i_mclk(i_mclk), .i_rst(i_rst), .o_req(i_req));
  task chk(string w, logic [8:0] s, e);
    cmp_count++;
    if (s !== e) begin fails++; $display("mismatch %s exp %h got %h", w, e, s); end
  endtask : chk
  task results;
    $display("fails %0d cmp_count %0d", fails, cmp_count);
    if (!fails && cmp_count) $display("STATUS OK"); else $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial begin
    void'($urandom(83));
    forever #5 i_mclk = ~i_mclk;
  end
  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (1200) @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
  end
  always @(posedge i_mclk) begin
    cycles++;
    if (i_rst) begin
      f = 0;
      m = 0;
      q.delete();
      q.push_back(0);
    end else begin
      chk("masked", {2'h0, o_pwm_irq, o_masked}, 9'({m != 0, m[5:0]}));
      chk("read", {o_rvalid, o_rdata}, 9'(q.pop_front()));
      rd_word = 0;
      if (i_req.rd) begin
        rd_word = 256;
        if (i_req.addr == pmi_pkg::PMI_MASKED_OFFSET) begin
          rd_word += f & int'(i_mask);
        end else if (i_req.addr == pmi_pkg::PMI_RAW_OFFSET) begin
          rd_word += f;
        end
      end
      q.push_back(rd_word);
      m = f & int'(i_mask);
      if (i_req.wr && i_req.addr == pmi_pkg::PMI_CLEAR_OFFSET) begin
        f &= ~int'(i_req.wdata[5:0]);
      end
      f |= int'(i_event);
    end
    i_event <= 6'($urandom & $urandom);
    i_mask <= 6'($urandom);
    i_timer_swreset <= 3'($urandom);
    if (cycles >= LIMIT) begin
      fails++;
      results;
    end else if (cmp_count >= 5000) begin
      results;
    end
  end
endmodule : tb_top
bind pmi_irq_status pmi_properties u_pmi_properties (.*);
`default_nettype wire
